// ==== logic/sucl_device.sv ====
// start-up configuration loader, device end
// What this block does
// - start-up begins when power_down_n rises
// - interface strap low selects I2C, high SPI
// - page equals strap page plus stored offset, zero if past page eight
// - stored offset reads zero from factory
// - ROM pages are constant, never writable
// - strap pairs map to pages zero to eight
// - page three starts with everything off
// - global soft reset restarts init and calibration
// - outputs resume after every loop relocks
// - per-loop reset recalibrates that loop only
// - same calibration after power-on and soft reset
// - ROM-only boot skips overlay, needs no host
// - overlay rewrites crystal, loop and driver settings
// - host writes DPLL, SYSREF, GPIO registers itself
// - ROM plus host boot accepts host overwrites
// - host soft-resets after changing loop registers
// - host skips reset for minor setting changes
// - host resets after zero-delay/SYSREF config
// - overlay_enable bit chooses overlay boot
`timescale 1ns/10ps
`include "sucl_params.svh"
module sucl_device (
  // system
  input wire logic clk,
  input wire logic rst,
  // link
  sucl_if.device lnk,
  // stored configuration (eeprom image of register 20)
  input wire logic [7:0] stored_cfg,
  input wire logic stored_cfg_valid,
  // results
  output logic spi_selected,
  output logic [3:0] rom_page,
  output logic overlay_applied,
  output logic low_power,
  output logic [7:0] active_cfg,
  output logic [2:0] loop_enable
);
  typedef struct packed {
    logic [1:0] pd_s;
    logic [1:0] ifs_s;
    logic [3:0] pl_s;
    logic [3:0] ph_s;
    logic [1:0] gsr_s;
    logic [5:0] plr_s;
    logic gsr_d;
    logic [2:0] plr_d;
    sucl_pkg::sucl_phase_t phase;
    logic [7:0] settle_cnt;
    logic [`SUCL_NUM_LOOPS-1:0][7:0] cal_cnt;
    logic [3:0] strap_lat;
    logic [2:0] cal_busy;
    logic spi;
    logic [3:0] page;
    logic ovl;
    logic lp;
    logic [7:0] cfg;
    logic [7:0] stored;
    logic [2:0] en;
    logic rdy;
  } sucl_dev_state_t;
  sucl_dev_state_t st_r, st_nxt;
  logic [3:0] strap_page;
  logic [4:0] page_sum;
  logic gsr_pulse;
  logic [2:0] plr_pulse;

  // fixed strap-to-page table: wiring only, no write path exists
  always_comb begin
    case (st_r.strap_lat)
      {`SUCL_LVL_L, `SUCL_LVL_L}: strap_page = 4'h0;
      {`SUCL_LVL_L, `SUCL_LVL_H}: strap_page = 4'h1;
      {`SUCL_LVL_H, `SUCL_LVL_L}: strap_page = 4'h2;
      {`SUCL_LVL_H, `SUCL_LVL_H}: strap_page = 4'h3;
      {`SUCL_LVL_L, `SUCL_LVL_M}: strap_page = 4'h4;
      {`SUCL_LVL_M, `SUCL_LVL_L}: strap_page = 4'h5;
      {`SUCL_LVL_M, `SUCL_LVL_M}: strap_page = 4'h6;
      {`SUCL_LVL_M, `SUCL_LVL_H}: strap_page = 4'h7;
      {`SUCL_LVL_H, `SUCL_LVL_M}: strap_page = 4'h8;
      default: strap_page = 4'h0;
    endcase
  end

  // five bits so a large offset cannot wrap back onto a legal page
  assign page_sum = {1'b0, strap_page} + {1'b0, st_r.stored[`SUCL_PAGE_OFS_HI:`SUCL_PAGE_OFS_LO]};
  assign gsr_pulse = st_r.gsr_s[1] & ~st_r.gsr_d;
  assign plr_pulse = st_r.plr_s[5:3] & ~st_r.plr_d;

  always_comb begin
    st_nxt = st_r;
    // pins pass two flops before use
    st_nxt.pd_s = {st_r.pd_s[0], lnk.power_down_n};
    st_nxt.ifs_s = {st_r.ifs_s[0], lnk.interface_strap_pin};
    st_nxt.pl_s = {st_r.pl_s[1:0], lnk.page_strap_low};
    st_nxt.ph_s = {st_r.ph_s[1:0], lnk.page_strap_high};
    st_nxt.gsr_s = {st_r.gsr_s[0], lnk.global_soft_reset};
    st_nxt.plr_s = {st_r.plr_s[2:0], lnk.per_loop_soft_reset};
    st_nxt.gsr_d = st_r.gsr_s[1];
    st_nxt.plr_d = st_r.plr_s[5:3];
    if (stored_cfg_valid) begin
      st_nxt.stored = stored_cfg;
    end
    for (int i = 0; i < `SUCL_NUM_LOOPS; i++) begin
      if (st_r.cal_busy[i]) begin
        if (st_r.cal_cnt[i] == 8'h00) begin
          st_nxt.cal_busy[i] = 1'b0;
          st_nxt.en[i] = ~st_r.lp;
        end else begin
          st_nxt.cal_cnt[i] = st_r.cal_cnt[i] - 8'h01;
        end
      end
    end

    case (st_r.phase)
      sucl_pkg::SUCL_OFF: begin
        if (st_r.pd_s[1]) begin
          st_nxt.phase = sucl_pkg::SUCL_SETTLE;
          st_nxt.settle_cnt = 8'(`SUCL_PD_SETTLE_CYC - 1);
        end
      end
      sucl_pkg::SUCL_SETTLE: begin
        if (st_r.settle_cnt == 8'h00) begin
          // straps sampled once here and held until next power-on
          st_nxt.spi = st_r.ifs_s[1];
          // a global soft reset reloads the page from this copy, not the pins
          st_nxt.strap_lat = {st_r.ph_s[3:2], st_r.pl_s[3:2]};
          st_nxt.phase = sucl_pkg::SUCL_ROM;
        end else begin
          st_nxt.settle_cnt = st_r.settle_cnt - 8'h01;
        end
      end
      sucl_pkg::SUCL_ROM: begin
        st_nxt.page = (page_sum < 5'(`SUCL_NUM_PAGES)) ? page_sum[3:0] : 4'h0;
        st_nxt.lp = (st_nxt.page == `SUCL_LOW_POWER_PAGE);
        st_nxt.cfg = `SUCL_STORED_RESET;
        st_nxt.ovl = 1'b0;
        if (st_r.stored[`SUCL_OVERLAY_BIT]) begin
          st_nxt.phase = sucl_pkg::SUCL_OVERLAY;
        end else begin
          st_nxt.phase = sucl_pkg::SUCL_CAL;
        end
      end
      sucl_pkg::SUCL_OVERLAY: begin
        st_nxt.cfg = st_r.stored;
        st_nxt.ovl = 1'b1;
        st_nxt.phase = sucl_pkg::SUCL_CAL;
      end
      sucl_pkg::SUCL_CAL: begin
        st_nxt.en = 3'h0;
        st_nxt.cal_busy = 3'h7;
        for (int i = 0; i < `SUCL_NUM_LOOPS; i++) begin
          st_nxt.cal_cnt[i] = 8'(`SUCL_CAL_CYC - 1);
        end
        st_nxt.phase = sucl_pkg::SUCL_RUN;
      end
      sucl_pkg::SUCL_RUN: begin
        // limitation: ready also drops while any single loop recalibrates
        st_nxt.rdy = (st_r.cal_busy == 3'h0);
        if (lnk.host_wr && st_nxt.rdy) begin
          st_nxt.cfg = lnk.host_wdata;
        end
        if (gsr_pulse) begin
          st_nxt.rdy = 1'b0;
          st_nxt.phase = sucl_pkg::SUCL_ROM;
        end else begin
          for (int i = 0; i < `SUCL_NUM_LOOPS; i++) begin
            if (plr_pulse[i]) begin
              st_nxt.en[i] = 1'b0;
              st_nxt.cal_busy[i] = 1'b1;
              st_nxt.cal_cnt[i] = 8'(`SUCL_CAL_CYC - 1);
            end
          end
        end
      end
      default: st_nxt.phase = sucl_pkg::SUCL_OFF;
    endcase

    // loss of power-down release restarts everything
    if (!st_r.pd_s[1]) begin
      st_nxt.phase = sucl_pkg::SUCL_OFF;
      st_nxt.rdy = 1'b0;
      st_nxt.en = 3'h0;
      st_nxt.cal_busy = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.stored <= `SUCL_STORED_RESET;
      st_r.phase <= sucl_pkg::SUCL_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spi_selected = st_r.spi;
  assign rom_page = st_r.page;
  assign overlay_applied = st_r.ovl;
  assign low_power = st_r.lp;
  assign active_cfg = st_r.cfg;
  assign loop_enable = st_r.en;
  assign lnk.ready = st_r.rdy;
  assign lnk.loop_locked = st_r.en;
endmodule

// ==== pkg/sucl_params.svh ====
// constants for the start-up configuration loader
`ifndef SUCL_PARAMS_SVH
`define SUCL_PARAMS_SVH
`define SUCL_CLK_PERIOD_NS 5
// power-down release filter, 100 ns
`define SUCL_PD_SETTLE_NS 100
`define SUCL_PD_SETTLE_CYC ((`SUCL_PD_SETTLE_NS + `SUCL_CLK_PERIOD_NS - 1) / `SUCL_CLK_PERIOD_NS)
// cycles per loop calibration, 1 us
`define SUCL_CAL_NS 1000
`define SUCL_CAL_CYC ((`SUCL_CAL_NS + `SUCL_CLK_PERIOD_NS - 1) / `SUCL_CLK_PERIOD_NS)
`define SUCL_NUM_LOOPS 3
// soft reset register and bit
`define SUCL_SOFT_RESET_REG 23
`define SUCL_SOFT_RESET_BIT 6
// stored configuration register 20 fields
`define SUCL_CFG_REG 20
`define SUCL_OVERLAY_BIT 7
`define SUCL_PAGE_OFS_HI 6
`define SUCL_PAGE_OFS_LO 3
`define SUCL_STORED_RESET 8'h00
`define SUCL_NUM_PAGES 9
`define SUCL_LOW_POWER_PAGE 4'h3
// three-level strap codes
`define SUCL_LVL_L 2'h0
`define SUCL_LVL_M 2'h1
`define SUCL_LVL_H 2'h2
`endif

// ==== pkg/sucl_pkg.sv ====
// types for the start-up configuration loader
package sucl_pkg;
  typedef enum logic [2:0] {
    SUCL_OFF,
    SUCL_SETTLE,
    SUCL_ROM,
    SUCL_OVERLAY,
    SUCL_CAL,
    SUCL_RUN
  } sucl_phase_t;
  typedef enum logic [1:0] {
    SUCL_BOOT_ROM,
    SUCL_BOOT_ROM_EE,
    SUCL_BOOT_ROM_EE_ISP,
    SUCL_BOOT_ROM_ISP
  } sucl_boot_t;
endpackage

// ==== pkg/sucl_if.sv ====
// link between the host end and the start-up loader end
`timescale 1ns/10ps
interface sucl_if;
  logic power_down_n;
  logic interface_strap_pin;
  logic [1:0] page_strap_low;
  logic [1:0] page_strap_high;
  logic global_soft_reset;
  logic [2:0] per_loop_soft_reset;
  logic host_wr;
  logic [7:0] host_wdata;
  logic ready;
  logic [2:0] loop_locked;
  modport device (
    input power_down_n, interface_strap_pin, page_strap_low, page_strap_high,
    input global_soft_reset, per_loop_soft_reset, host_wr, host_wdata,
    output ready, loop_locked
  );
  modport host (
    output power_down_n, interface_strap_pin, page_strap_low, page_strap_high,
    output global_soft_reset, per_loop_soft_reset, host_wr, host_wdata,
    input ready, loop_locked
  );
endinterface

// ==== logic/sucl_host.sv ====
// host end: straps, power-down release and soft-reset requests
`timescale 1ns/10ps
`include "sucl_params.svh"
module sucl_host (
  // system
  input wire logic clk,
  input wire logic rst,
  // link
  sucl_if.host lnk,
  // board straps and user commands
  input wire logic power_up,
  input wire logic strap_spi,
  input wire logic [1:0] strap_low,
  input wire logic [1:0] strap_high,
  input wire logic cmd_global_reset,
  input wire logic [2:0] cmd_loop_reset,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_wdata,
  // status
  output logic device_ready
);
  typedef struct packed {
    logic pd;
    logic ifs;
    logic [1:0] pl;
    logic [1:0] ph;
    logic gsr;
    logic [2:0] plr;
    logic wr;
    logic [7:0] wd;
    logic [1:0] rdy_s;
  } sucl_host_state_t;
  sucl_host_state_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pd = power_up;
    st_nxt.ifs = strap_spi;
    st_nxt.pl = strap_low;
    st_nxt.ph = strap_high;
    st_nxt.rdy_s = {st_r.rdy_s[0], lnk.ready};
    // reset requests held as levels; device edge-detects them
    st_nxt.gsr = cmd_global_reset;
    st_nxt.plr = cmd_loop_reset;
    st_nxt.wr = cmd_write & st_r.rdy_s[1];
    st_nxt.wd = cmd_wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.power_down_n = st_r.pd;
  assign lnk.interface_strap_pin = st_r.ifs;
  assign lnk.page_strap_low = st_r.pl;
  assign lnk.page_strap_high = st_r.ph;
  assign lnk.global_soft_reset = st_r.gsr;
  assign lnk.per_loop_soft_reset = st_r.plr;
  assign lnk.host_wr = st_r.wr;
  assign lnk.host_wdata = st_r.wd;
  assign device_ready = st_r.rdy_s[1];
endmodule

// ==== bench/sucl_asserts.sv ====
// assertions on the loader link
`timescale 1ns/10ps
module sucl_asserts (
  // system
  input wire logic clk,
  input wire logic rst,
  // host side
  input wire logic power_down_n,
  input wire logic global_soft_reset,
  input wire logic [2:0] per_loop_soft_reset,
  // device side
  input wire logic ready,
  input wire logic [2:0] loop_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_RDY_POWER: assert property ($rose(ready) |-> power_down_n)
    else $error("ready rose while powered down");
  AST_BOOT_WAIT: assert property ($rose(power_down_n) |-> ##1 !ready [*8])
    else $error("ready too early after power up");
  AST_BOOT_DONE: assert property ($rose(power_down_n) ##1 power_down_n [*8] |-> ##[200:240] ready)
    else $error("boot did not finish alone");
  AST_PD_OFF: assert property ($fell(power_down_n) |-> ##[1:6] (!ready && loop_locked == 3'h0))
    else $error("power down did not stop device");
  AST_GLOBAL: assert property (ready && $rose(global_soft_reset) |-> ##[1:6] !ready)
    else $error("global reset did not restart");
  AST_GLOBAL_LOOPS: assert property (ready && $rose(global_soft_reset) |-> ##[1:8] loop_locked == 3'h0)
    else $error("loops kept running over global reset");
  // only loop one may drop, and it must come back after one calibration
  AST_LOOP_ONLY: assert property (ready && loop_locked == 3'h7 && $rose(per_loop_soft_reset[1])
    |-> ##[1:6] loop_locked == 3'h5 ##[180:230] loop_locked == 3'h7)
    else $error("per loop reset disturbed other loops");
  AST_LOCK_SET: assert property ($rose(ready) |-> loop_locked == 3'h7 || loop_locked == 3'h0)
    else $error("partial loop set at ready");
endmodule

// ==== bench/sucl_tb.sv ====
// self-checking bench for the start-up loader
`timescale 1ns/10ps
module sucl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_up = 1'b0, strap_spi = 1'b0, cmd_global_reset = 1'b0, cmd_write = 1'b0;
  logic stored_cfg_valid = 1'b0;
  logic [1:0] strap_low = 2'h0, strap_high = 2'h0;
  logic [2:0] cmd_loop_reset = 3'h0;
  logic [7:0] cmd_wdata = 8'h00, stored_cfg = 8'h00;
  logic spi_selected, overlay_applied, low_power, device_ready;
  logic [3:0] rom_page;
  logic [7:0] active_cfg;
  logic [2:0] loop_enable;
  int n_errors = 0, n_compared = 0, cycles = 0;
  // strap pairs in page order, high then low
  logic [1:0] hi_tab [9] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
  logic [1:0] lo_tab [9] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1};
  sucl_if lnk ();
  sucl_host u_sucl_host (.clk(clk), .rst(rst), .lnk(lnk.host), .power_up(power_up), .strap_spi(strap_spi),
    .strap_low(strap_low), .strap_high(strap_high), .cmd_global_reset(cmd_global_reset),
    .cmd_loop_reset(cmd_loop_reset), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .device_ready(device_ready));
  sucl_device u_sucl_device (.clk(clk), .rst(rst), .lnk(lnk.device), .stored_cfg(stored_cfg),
    .stored_cfg_valid(stored_cfg_valid), .spi_selected(spi_selected), .rom_page(rom_page),
    .overlay_applied(overlay_applied), .low_power(low_power), .active_cfg(active_cfg), .loop_enable(loop_enable));
  sucl_asserts u_sucl_asserts (.clk(clk), .rst(rst), .power_down_n(lnk.power_down_n),
    .global_soft_reset(lnk.global_soft_reset), .per_loop_soft_reset(lnk.per_loop_soft_reset),
    .ready(lnk.ready), .loop_locked(lnk.loop_locked));
  always #2.5 clk = ~clk;
  // about 3300 cycles expected, generous ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // ready must fall first, so give the request time to land
  task automatic wait_ready();
    int i;
    i = 0;
    tick(8);
    while (device_ready !== 1'b1 && i < 600) begin
      tick(1);
      i++;
    end
    chk("ready", {7'h00, device_ready}, 8'h01);
  endtask
  task automatic boot(logic spi, logic [1:0] hi, logic [1:0] lo);
    power_up = 1'b0;
    tick(10);
    strap_spi = spi;
    strap_high = hi;
    strap_low = lo;
    power_up = 1'b1;
    wait_ready();
  endtask
  task automatic results(logic spi, logic [3:0] page, logic ovl, logic [7:0] cfg);
    chk("spi", {7'h00, spi_selected}, {7'h00, spi});
    chk("page", {4'h0, rom_page}, {4'h0, page});
    chk("overlay", {7'h00, overlay_applied}, {7'h00, ovl});
    chk("cfg", active_cfg, cfg);
  endtask
  initial begin
    tick(12);
    rst = 1'b0;
    boot(1'b0, 2'h0, 2'h0);
    results(1'b0, 4'h0, 1'b0, 8'h00);
    $display("factory boot done");
    for (int p = 0; p < 9; p++) begin
      boot(p[0], hi_tab[p], lo_tab[p]);
      results(p[0], p[3:0], 1'b0, 8'h00);
      chk("low power", {7'h00, low_power}, {7'h00, p == 3});
      chk("loops", {5'h00, loop_enable}, (p == 3) ? 8'h00 : 8'h07);
    end
    $display("page table done");
    cmd_wdata = 8'h5A;
    cmd_write = 1'b1;
    tick(1);
    cmd_wdata = 8'hA5;
    tick(1);
    cmd_write = 1'b0;
    tick(6);
    chk("host byte", active_cfg, 8'hA5);
    strap_spi = 1'b1;
    strap_high = 2'h0;
    cmd_global_reset = 1'b1;
    tick(2);
    cmd_global_reset = 1'b0;
    wait_ready();
    results(1'b0, 4'h8, 1'b0, 8'h00);
    cmd_loop_reset = 3'h2;
    tick(2);
    cmd_loop_reset = 3'h0;
    tick(6);
    chk("one loop", {5'h00, loop_enable}, 8'h05);
    tick(210);
    chk("loop back", {5'h00, loop_enable}, 8'h07);
    $display("soft reset done");
    stored_cfg = 8'h90;
    stored_cfg_valid = 1'b1;
    boot(1'b1, 2'h0, 2'h0);
    results(1'b1, 4'h2, 1'b1, 8'h90);
    // offset pushes the sum past the last page
    stored_cfg = 8'h88;
    boot(1'b0, 2'h2, 2'h1);
    results(1'b0, 4'h0, 1'b1, 8'h88);
    $display("overlay done");
    give_verdict();
  end
endmodule
